// ==== src/lstr_regs.sv ====
// Summary of operation
// RL1: closed loop on: drive code is selected setpoint plus signed bias lookup.
// RL2: closed loop off: drive code is selected setpoint, lookup ignored.
// RL3: applied bias drive code is readable in the bias report register.
// RL4: select 01 uses setpoint one, select 10 uses setpoint two.
// RL5: select 00 uses setpoint zero.
// RL6: polarity bits decide whether the drive code is inverted.
// RL7: closed loop on: modulation code is setpoint plus modulation lookup.
// RL8: bias current above its limit raises the bias fault.
// RL9: transmit power above its limit raises the transmit fault.
// RL10: received power below its limit raises the loss-of-signal fault.
// RL11: registers are read or written only with a valid password.
// RL12: register contents are non-volatile and survive reset.
// RL13: each register is eight bits, read/write, default zero; the bias report register is read-only and ignores writes.
// RL14: sums outside the eight-bit range clamp to the nearest end.
// RL15: thresholds compare unsigned against measurements of the same scale.
`timescale 1ns/10ps
`default_nettype none
module lstr_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic password_ok,
  input wire logic closed_loop_on_bit,
  input wire logic [1:0] setpoint_select_field,
  input wire logic bias_code_polarity_bits,
  input wire logic signed [7:0] bias_lookup_value,
  input wire logic signed [7:0] modulation_lookup_table,
  input wire logic [7:0] meas_bias_current,
  input wire logic [7:0] meas_tx_power,
  input wire logic [7:0] meas_rx_power,
  output logic [7:0] bias_drive_code,
  output logic [7:0] modulation_drive,
  output logic bias_current_fault,
  output logic tx_power_fault,
  output logic rx_signal_loss_fault
);

  // unsigned code plus signed offset, clamped to the code range
  function automatic logic [7:0] sat_add(input logic [7:0] base, input logic signed [7:0] ofs);
    logic signed [9:0] sum;
    sum = $signed({2'b00, base}) + 10'(ofs);
    if (sum > $signed({2'b00, lstr_pkg::CODE_MAX}))
      sat_add = lstr_pkg::CODE_MAX; // RL14
    else if (sum < 10'sd0)
      sat_add = lstr_pkg::CODE_MIN; // RL14
    else
      sat_add = sum[7:0];
  endfunction

  // non-volatile contents: not touched by rstn, power-up value zero
  logic [7:0] bias_setpoint_zero_reg = lstr_pkg::SETPOINT_DEFAULT; // RL12
  logic [7:0] bias_setpoint_one_reg = lstr_pkg::SETPOINT_DEFAULT; // RL13
  logic [7:0] bias_setpoint_two_reg = lstr_pkg::SETPOINT_DEFAULT;
  logic [7:0] modulation_setpoint_reg = lstr_pkg::SETPOINT_DEFAULT;
  logic [7:0] bias_current_fault_limit_reg = lstr_pkg::SETPOINT_DEFAULT;
  logic [7:0] tx_power_fault_limit_reg = lstr_pkg::SETPOINT_DEFAULT;
  logic [7:0] rx_signal_loss_limit_reg = lstr_pkg::SETPOINT_DEFAULT;

  logic [7:0] bias_raw_reg;
  logic [7:0] bias_raw_next;
  logic [7:0] selected_setpoint;
  logic [7:0] modulation_next;
  logic wr_ok;

  assign wr_ok = reg_wr && password_ok; // RL11

  // register writes, guarded by the password
  always_ff @(posedge clk)
  begin
    if (wr_ok)
    begin
      unique case (reg_addr)
        lstr_pkg::BIAS_SETPOINT_ZERO_OFS: bias_setpoint_zero_reg <= reg_wdata; // RL13
        lstr_pkg::BIAS_SETPOINT_ONE_OFS: bias_setpoint_one_reg <= reg_wdata;
        lstr_pkg::BIAS_SETPOINT_TWO_OFS: bias_setpoint_two_reg <= reg_wdata;
        lstr_pkg::MODULATION_SETPOINT_OFS: modulation_setpoint_reg <= reg_wdata;
        lstr_pkg::BIAS_CURRENT_FAULT_LIMIT_OFS: bias_current_fault_limit_reg <= reg_wdata;
        lstr_pkg::TX_POWER_FAULT_LIMIT_OFS: tx_power_fault_limit_reg <= reg_wdata;
        lstr_pkg::RX_SIGNAL_LOSS_LIMIT_OFS: rx_signal_loss_limit_reg <= reg_wdata;
        default:
        begin
        end
      endcase
    end
  end

  // read port: zero without password or at unmapped offsets
  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= lstr_pkg::READ_IDLE;
    else if (reg_rd)
    begin
      if (!password_ok)
        reg_rdata <= lstr_pkg::READ_IDLE; // RL11
      else
      begin
        unique case (reg_addr)
          lstr_pkg::BIAS_SETPOINT_ZERO_OFS: reg_rdata <= bias_setpoint_zero_reg;
          lstr_pkg::BIAS_SETPOINT_ONE_OFS: reg_rdata <= bias_setpoint_one_reg;
          lstr_pkg::BIAS_SETPOINT_TWO_OFS: reg_rdata <= bias_setpoint_two_reg;
          lstr_pkg::MODULATION_SETPOINT_OFS: reg_rdata <= modulation_setpoint_reg;
          lstr_pkg::BIAS_CURRENT_FAULT_LIMIT_OFS: reg_rdata <= bias_current_fault_limit_reg;
          lstr_pkg::TX_POWER_FAULT_LIMIT_OFS: reg_rdata <= tx_power_fault_limit_reg;
          lstr_pkg::RX_SIGNAL_LOSS_LIMIT_OFS: reg_rdata <= rx_signal_loss_limit_reg;
          lstr_pkg::BIAS_DRIVE_REPORT_OFS: reg_rdata <= bias_drive_code; // RL3
          default: reg_rdata <= lstr_pkg::READ_IDLE;
        endcase
      end
    end
  end

  // setpoint selection; code 11 falls back to setpoint zero
  always_comb
  begin
    unique case (setpoint_select_field)
      lstr_pkg::SEL_ONE: selected_setpoint = bias_setpoint_one_reg; // RL4
      lstr_pkg::SEL_TWO: selected_setpoint = bias_setpoint_two_reg; // RL4
      default: selected_setpoint = bias_setpoint_zero_reg; // RL5
    endcase
  end

  // closed loop adds the lookups, open loop passes setpoints through
  always_comb
  begin
    if (closed_loop_on_bit)
    begin
      bias_raw_next = sat_add(selected_setpoint, bias_lookup_value); // RL1
      modulation_next = sat_add(modulation_setpoint_reg, modulation_lookup_table); // RL7
    end
    else
    begin
      bias_raw_next = selected_setpoint; // RL2
      modulation_next = modulation_setpoint_reg;
    end
  end

  // converter codes, bias code inverted when polarity asks for it
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bias_raw_reg <= lstr_pkg::CODE_MIN;
      bias_drive_code <= lstr_pkg::CODE_MIN;
      modulation_drive <= lstr_pkg::CODE_MIN;
    end
    else
    begin
      bias_raw_reg <= bias_raw_next;
      bias_drive_code <= bias_code_polarity_bits ? ~bias_raw_next : bias_raw_next; // RL6
      modulation_drive <= modulation_next;
    end
  end

  // unsigned threshold comparisons
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bias_current_fault <= 1'b0;
      tx_power_fault <= 1'b0;
      rx_signal_loss_fault <= 1'b0;
    end
    else
    begin
      bias_current_fault <= meas_bias_current > bias_current_fault_limit_reg; // RL8 RL15
      tx_power_fault <= meas_tx_power > tx_power_fault_limit_reg; // RL9
      rx_signal_loss_fault <= meas_rx_power < rx_signal_loss_limit_reg; // RL10
    end
  end

  // open-loop cycle with a given select code
  sequence open_sel_s(logic [1:0] code);
    !closed_loop_on_bit && setpoint_select_field == code;
  endsequence

  // write attempt without the password
  sequence locked_wr_s;
    reg_wr && !password_ok && reg_addr == lstr_pkg::BIAS_SETPOINT_ONE_OFS;
  endsequence

  // report read with the password
  sequence report_rd_s;
    reg_rd && password_ok && reg_addr == lstr_pkg::BIAS_DRIVE_REPORT_OFS;
  endsequence

  // write with the password to the modulation setpoint
  sequence open_wr_s;
    reg_wr && password_ok && reg_addr == lstr_pkg::MODULATION_SETPOINT_OFS;
  endsequence

  sel_one_path_a: assert property (@(posedge clk) disable iff (!rstn) // RL4
    open_sel_s(lstr_pkg::SEL_ONE) |=> bias_raw_reg == $past(bias_setpoint_one_reg))
    else $error("setpoint one not applied");

  sel_two_path_a: assert property (@(posedge clk) disable iff (!rstn) // RL4
    open_sel_s(lstr_pkg::SEL_TWO) |=> bias_raw_reg == $past(bias_setpoint_two_reg))
    else $error("setpoint two not applied");

  sel_zero_path_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
    open_sel_s(lstr_pkg::SEL_ZERO) |=> bias_raw_reg == $past(bias_setpoint_zero_reg))
    else $error("setpoint zero not applied");

  open_loop_bypass_a: assert property (@(posedge clk) disable iff (!rstn) // RL2
    !closed_loop_on_bit ##1 !closed_loop_on_bit && $stable(selected_setpoint)
      && $changed(bias_lookup_value) |=> $stable(bias_raw_reg))
    else $error("lookup leaked into open-loop code");

  closed_sum_a: assert property (@(posedge clk) disable iff (!rstn) // RL1
    closed_loop_on_bit && selected_setpoint == 8'h10 && bias_lookup_value == -8'sd3
      |=> bias_raw_reg == 8'h0d)
    else $error("closed-loop bias sum wrong");

  clamp_high_a: assert property (@(posedge clk) disable iff (!rstn) // RL14
    closed_loop_on_bit && selected_setpoint == 8'hff && bias_lookup_value > 8'sd0
      |=> bias_raw_reg == lstr_pkg::CODE_MAX)
    else $error("bias code wrapped above range");

  clamp_low_a: assert property (@(posedge clk) disable iff (!rstn) // RL14
    closed_loop_on_bit && modulation_setpoint_reg == 8'h00 && modulation_lookup_table < 8'sd0
      |=> modulation_drive == lstr_pkg::CODE_MIN)
    else $error("modulation code wrapped below range");

  mod_sum_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    closed_loop_on_bit && modulation_lookup_table == 8'sd5 && modulation_setpoint_reg < 8'hf0
      |=> modulation_drive == $past(modulation_setpoint_reg) + 8'h05)
    else $error("modulation sum wrong");

  code_polarity_a: assert property (@(posedge clk) disable iff (!rstn) // RL6
    ##1 bias_drive_code == ($past(bias_code_polarity_bits) ? ~bias_raw_reg : bias_raw_reg))
    else $error("bias code polarity wrong");

  report_read_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
    report_rd_s |=> reg_rdata == $past(bias_drive_code))
    else $error("bias report mismatch");

  bias_fault_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
    meas_bias_current > bias_current_fault_limit_reg |=> bias_current_fault)
    else $error("bias fault missed");

  tx_fault_a: assert property (@(posedge clk) disable iff (!rstn) // RL9
    meas_tx_power <= tx_power_fault_limit_reg |=> !tx_power_fault)
    else $error("false transmit fault");

  los_fault_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    meas_rx_power < rx_signal_loss_limit_reg |=> rx_signal_loss_fault)
    else $error("loss of signal missed");

  locked_write_a: assert property (@(posedge clk) disable iff (!rstn) // RL11
    locked_wr_s |=> $stable(bias_setpoint_one_reg))
    else $error("write accepted without password");

  locked_read_a: assert property (@(posedge clk) disable iff (!rstn) // RL11
    reg_rd && !password_ok |=> reg_rdata == lstr_pkg::READ_IDLE)
    else $error("read data leaked without password");

  nv_keep_a: assert property (@(posedge clk) // RL12
    !rstn && !reg_wr |=> $stable(modulation_setpoint_reg))
    else $error("register lost over reset");

  sel_spare_path_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
    open_sel_s(2'h3) |=> bias_raw_reg == $past(bias_setpoint_zero_reg))
    else $error("spare select code not on setpoint zero");

  clamp_floor_a: assert property (@(posedge clk) disable iff (!rstn) // RL14
    closed_loop_on_bit && selected_setpoint < 8'h80 && bias_lookup_value == 8'sh80
      |=> bias_raw_reg == lstr_pkg::CODE_MIN)
    else $error("bias code wrapped below range");

  closed_invert_a: assert property (@(posedge clk) disable iff (!rstn) // RL6
    closed_loop_on_bit && bias_code_polarity_bits && selected_setpoint == 8'h10
      && bias_lookup_value == -8'sd3 |=> bias_drive_code == 8'hf2)
    else $error("inverted closed-loop code wrong");

  mod_open_path_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    !closed_loop_on_bit |=> modulation_drive == $past(modulation_setpoint_reg))
    else $error("open-loop modulation code wrong");

  bias_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
    meas_bias_current <= bias_current_fault_limit_reg |=> !bias_current_fault)
    else $error("false bias fault");

  tx_fault_hit_a: assert property (@(posedge clk) disable iff (!rstn) // RL9
    meas_tx_power > tx_power_fault_limit_reg |=> tx_power_fault)
    else $error("transmit fault missed");

  los_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    meas_rx_power >= rx_signal_loss_limit_reg |=> !rx_signal_loss_fault)
    else $error("false loss of signal");

  open_write_a: assert property (@(posedge clk) disable iff (!rstn) // RL13
    open_wr_s |=> modulation_setpoint_reg == $past(reg_wdata))
    else $error("write with password not stored");

  rdata_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RL13
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  report_no_write_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
    reg_wr && reg_addr == lstr_pkg::BIAS_DRIVE_REPORT_OFS
      |=> $stable(bias_setpoint_zero_reg) && $stable(modulation_setpoint_reg))
    else $error("write to bias report altered storage");

endmodule
`default_nettype wire

// ==== common/lstr_pkg.sv ====
`default_nettype none
package lstr_pkg;
  // register byte offsets on the serial-bus register page
  localparam logic [7:0] BIAS_SETPOINT_ZERO_OFS = 8'h03;
  localparam logic [7:0] BIAS_SETPOINT_ONE_OFS = 8'h04;
  localparam logic [7:0] BIAS_SETPOINT_TWO_OFS = 8'h05;
  localparam logic [7:0] MODULATION_SETPOINT_OFS = 8'h06;
  localparam logic [7:0] BIAS_CURRENT_FAULT_LIMIT_OFS = 8'h07;
  localparam logic [7:0] TX_POWER_FAULT_LIMIT_OFS = 8'h08;
  localparam logic [7:0] RX_SIGNAL_LOSS_LIMIT_OFS = 8'h09;
  localparam logic [7:0] BIAS_DRIVE_REPORT_OFS = 8'h60;
  // reset and power-up contents, and the code range limits
  localparam logic [7:0] SETPOINT_DEFAULT = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [7:0] CODE_MIN = 8'h00;
  // setpoint select encodings
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
endpackage
`default_nettype wire

// ==== tb/lstr_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lstr_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic password_ok,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    password_ok = 1'b0;
  end
  // password presented before any access
  task automatic set_pw(input logic ok);
    @(negedge clk);
    password_ok = ok;
  endtask
  // one write byte, strobe held for one edge
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data keeps no stale value
  endtask
  // one read byte, data taken half a cycle after the strobe edge
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/laser_setpoint_threshold_regs_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module laser_setpoint_threshold_regs_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, bias, modv, mb = 8'h00, mt = 8'h00, mr = 8'h00;
  logic wr, rd, pw, bf, tf, lf;
  logic cl = 1'b0;
  logic pol = 1'b0;
  logic [1:0] sel = 2'h0;
  logic signed [7:0] blut = 8'sh00;
  logic signed [7:0] mlut = 8'sh00;
  int bad_count = 0;
  int comparisons = 0;
  // clock, 50 ns period
  always #25 clk = ~clk;
  lstr_host u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .password_ok(pw), .reg_rdata(rdata));
  lstr_regs u_dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .password_ok(pw), .closed_loop_on_bit(cl),
    .setpoint_select_field(sel), .bias_code_polarity_bits(pol), .bias_lookup_value(blut),
    .modulation_lookup_table(mlut), .meas_bias_current(mb), .meas_tx_power(mt),
    .meas_rx_power(mr), .bias_drive_code(bias), .modulation_drive(modv),
    .bias_current_fault(bf), .tx_power_fault(tf), .rx_signal_loss_fault(lf));
  // compare one byte result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd_byte(a, v);
    chk(v, exp);
  endtask
  // apply control inputs, then let the registered codes update
  task automatic drive(input logic c, input logic [1:0] s, input logic p, input logic [7:0] l);
    @(negedge clk);
    cl = c;
    sel = s;
    pol = p;
    blut = l;
    repeat (2) @(negedge clk);
  endtask
  // power-up contents and full write/read of the bank
  task automatic t_access;
    u_host.set_pw(1'b1);
    for (int a = 3; a <= 9; a++) rd_chk(8'(a), 8'h00);
    for (int a = 3; a <= 9; a++) u_host.wr_byte(8'(a), 8'(a) + 8'h30);
    for (int a = 3; a <= 9; a++) rd_chk(8'(a), 8'(a) + 8'h30);
    u_host.wr_byte(8'h42, 8'h5a);
    rd_chk(8'h42, 8'h00);
    $display("test access done");
  endtask
  // locked bank refuses writes and reads zero
  task automatic t_password;
    u_host.set_pw(1'b0);
    u_host.wr_byte(8'h04, 8'hee);
    rd_chk(8'h04, 8'h00);
    u_host.set_pw(1'b1);
    rd_chk(8'h04, 8'h34);
    $display("test password done");
  endtask
  // mid-run reset keeps stored values
  task automatic t_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rd_chk(8'h07, 8'h37);
    rd_chk(8'h05, 8'h35);
    $display("test reset done");
  endtask
  // bias drive codes in both loop modes, modulation drive code in closed loop only
  task automatic t_drive;
    drive(1'b0, 2'h0, 1'b0, 8'hfd);
    chk(bias, 8'h33);
    drive(1'b0, 2'h1, 1'b0, 8'hfd);
    chk(bias, 8'h34);
    drive(1'b0, 2'h2, 1'b0, 8'hfd);
    chk(bias, 8'h35);
    drive(1'b0, 2'h2, 1'b0, 8'h05);
    chk(bias, 8'h35);
    u_host.wr_byte(8'h60, 8'hff);
    rd_chk(8'h60, 8'h35);
    drive(1'b0, 2'h3, 1'b0, 8'h05);
    chk(bias, 8'h33);
    drive(1'b1, 2'h1, 1'b0, 8'hfd);
    chk(bias, 8'h31);
    drive(1'b1, 2'h1, 1'b1, 8'hfd);
    chk(bias, 8'hce);
    rd_chk(8'h60, 8'hce);
    drive(1'b1, 2'h1, 1'b0, 8'h80);
    chk(bias, 8'h00);
    u_host.wr_byte(8'h05, 8'hff);
    drive(1'b1, 2'h2, 1'b0, 8'h7f);
    chk(bias, 8'hff);
    mlut = 8'sh05;
    drive(1'b1, 2'h2, 1'b0, 8'h7f);
    chk(modv, 8'h3b);
    u_host.wr_byte(8'h06, 8'h00);
    mlut = 8'shfb;
    drive(1'b1, 2'h2, 1'b0, 8'h7f);
    chk(modv, 8'h00);
    u_host.wr_byte(8'h04, 8'h10);
    drive(1'b1, 2'h1, 1'b0, 8'hfd);
    chk(bias, 8'h0d);
    drive(1'b1, 2'h1, 1'b1, 8'hfd);
    chk(bias, 8'hf2);
    $display("test drive done");
  endtask
  // fault thresholds at their boundaries
  task automatic t_faults;
    drive(1'b0, 2'h0, 1'b0, 8'h00);
    mb = 8'h37;
    mt = 8'h38;
    mr = 8'h39;
    repeat (2) @(negedge clk);
    chk({5'h00, bf, tf, lf}, 8'h00);
    mb = 8'h38;
    mt = 8'h39;
    mr = 8'h38;
    repeat (2) @(negedge clk);
    chk({5'h00, bf, tf, lf}, 8'h07);
    $display("test faults done");
  endtask
  // counts and verdict
  task automatic conclude;
    $display("compared %0d, wrong %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_access();
    t_password();
    t_reset();
    t_drive();
    t_faults();
    conclude();
  end
  // watchdog, well beyond the roughly 134 cycles needed
  initial
  begin
    #200us;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
